// ===== verilog/sfp_port.sv
// Serial frame port: link-side shifters, crossings, buffer, pin modes
`default_nettype none
module sfp_port (
  input wire logic ref_clk,
  input wire logic rst,
  // Link pins; serial_clk is the link-domain clock
  input wire logic serial_clk,
  input wire logic sync_n,
  input wire logic serial_in,
  output logic serial_out,
  // Received words toward the core
  output logic [15:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overrun,
  // Outgoing word offered by the core
  input wire logic [15:0] tx_data,
  input wire logic tx_load,
  // Pin functions and pin data
  input wire logic [15:0] pin_fn,
  input wire logic [7:0] pin_out_val,
  input wire logic busy_en,
  input wire logic conv_busy,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_o,
  output logic [7:0] pin_in_val,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_analog
);
  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic [15:0] rx_shift;
  logic [4:0] bit_cnt;
  logic [15:0] rx_word;
  logic rx_tog;
  logic [4:0] tx_shift;
  logic fell;
  logic [15:0] tx_hold;
  logic [15:0] tx_frame;

  // Frame sync high clears state between frames, so idle polarity is free
  always_ff @(negedge serial_clk or posedge sync_n) begin
    if (sync_n) begin
      bit_cnt <= 5'h00;
      rx_shift <= sfp_pkg::WORD_RST;
      fell <= 1'b0;
    end else if (bit_cnt != sfp_pkg::CNT_FULL) begin
      rx_shift <= {rx_shift[14:0], serial_in};
      bit_cnt <= bit_cnt + 5'h01;
      fell <= 1'b1;
    end
  end

  // Completed word is latched and its arrival toggled; core reset clears
  // the toggle so the crossing starts from a known level, and the link
  // clock stands idle while that reset is held
  always_ff @(negedge serial_clk or posedge rst) begin
    if (rst) begin
      rx_word <= sfp_pkg::WORD_RST;
      rx_tog <= 1'b0;
    end else if (!sync_n && bit_cnt == 5'h0F) begin
      rx_word <= {rx_shift[14:0], serial_in};
      rx_tog <= ~rx_tog;
    end
  end

  // Outgoing word is frozen at sync fall; MSB shows at once
  always_ff @(negedge sync_n) begin
    tx_frame <= tx_hold;
  end

  // Later bits launch on rising edges after a falling edge; the count
  // stops at a full word so extra clocks cannot wrap back into it
  always_ff @(posedge serial_clk or posedge sync_n) begin
    if (sync_n) begin
      tx_shift <= 5'h00;
    end else if (fell && tx_shift != sfp_pkg::CNT_FULL) begin
      tx_shift <= tx_shift + 5'h01; // Count of bits shifted
    end
  end

  // MSB first from the frozen word
  assign serial_out = (tx_shift < sfp_pkg::CNT_FULL) ?
    tx_frame[4'hF - tx_shift[3:0]] : 1'b0;

  // ----------------------------------------------------------------
  // Reference domain
  // ----------------------------------------------------------------
  logic [2:0] tog_s;
  logic rx_pend;
  logic [15:0] rx_cap;
  logic buf_ready;
  logic rx_arrive;

  // Toggle crossing of word arrival
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tog_s <= 3'h0;
    end else begin
      tog_s <= {tog_s[1:0], rx_tog};
    end
  end

  // New word seen once the second flop of the crossing has it
  assign rx_arrive = (tog_s[2] != tog_s[1]);

  // Word is latched with its toggle and holds until the next frame completes, well after the toggle is seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_pend <= 1'b0;
      rx_cap <= sfp_pkg::WORD_RST;
    end else if (rx_arrive) begin
      rx_cap <= rx_word;
      rx_pend <= 1'b1;
    end else if (buf_ready) begin
      rx_pend <= 1'b0;
    end
  end

  // A new word while the last still waits on a full buffer drops that one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_overrun <= 1'b0;
    end else begin
      rx_overrun <= rx_arrive && rx_pend && !buf_ready;
    end
  end

  sfp_buf2 u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(rx_cap),
    .in_valid(rx_pend),
    .in_ready(buf_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // Outgoing word held for the next frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_hold <= sfp_pkg::WORD_RST;
    end else if (tx_load) begin
      tx_hold <= tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;

  // Input pins pass two flip-flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end else begin
      pin_s1 <= pin_i;
      pin_s2 <= pin_s1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < sfp_pkg::PINS; gi++) begin : g_pin
      logic [1:0] fn;
      logic busy_sel;
      logic next_oe;
      logic next_o;
      logic next_analog;
      logic next_in;
      assign fn = pin_fn[2*gi+1:2*gi];
      assign busy_sel = (gi == sfp_pkg::BUSY_PIN) && busy_en;

      // Each pin decoded on its own; busy overrides pin seven's drive and analog switch, not its input value
      always_comb begin
        next_oe = busy_sel || (fn == sfp_pkg::SFP_PIN_DOUT);
        next_o = busy_sel ? conv_busy : pin_out_val[gi];
        next_analog = !busy_sel &&
          (fn == sfp_pkg::SFP_PIN_AOUT || fn == sfp_pkg::SFP_PIN_AIN);
        next_in = (fn == sfp_pkg::SFP_PIN_DIN) && pin_s2[gi];
      end

      // Output enable, high while the pin is driven
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pin_oe[gi] <= 1'b0;
        end else begin
          pin_oe[gi] <= next_oe;
        end
      end

      // Driven level, busy state or written value
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pin_o[gi] <= 1'b0;
        end else begin
          pin_o[gi] <= next_o;
        end
      end

      // Analog switch for converter input or output
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pin_analog[gi] <= 1'b0;
        end else begin
          pin_analog[gi] <= next_analog;
        end
      end

      // Level of a digital input, zero for other functions
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pin_in_val[gi] <= 1'b0;
        end else begin
          pin_in_val[gi] <= next_in;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== include/sfp_pkg.sv
// Constants shared by the serial frame port design
// Notes on behaviour
// - Serial input is sampled into the input shift register on each of the first 16 falling serial clock edges of an active frame.
// - A frame starts when frame sync goes low and takes exactly the next 16 falling clock edges as its bits.
// - When frame sync falls, the most significant outgoing bit appears on serial output at once.
// - Each later output bit is launched on the first rising clock edge after a falling edge while sync is low.
// - The serial clock may idle high or low between frames and either works.
// - The output stream carries converter results, readback and temperature data, most significant bit first.
// - Each general pin takes its own selected function: analog out, analog in, digital in or digital out.
// - When so configured, pin seven shows busy while a conversion is in progress.
`default_nettype none
package sfp_pkg;
  // ----------------------------------------------------------------
  // Frame shape
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int PINS = 8;
  localparam int BUSY_PIN = 7;
  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFP_PIN_AOUT = 2'b00,
    SFP_PIN_AIN = 2'b01,
    SFP_PIN_DIN = 2'b10,
    SFP_PIN_DOUT = 2'b11
  } sfp_pin_fn_t;
endpackage
`default_nettype wire

// ===== verilog/sfp_buf2.sv
// Two-entry valid/ready buffer for received frame words
`default_nettype none
module sfp_buf2 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [15:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [15:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage written by index
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ===== sim/sfp_port_chk.sv
// Checker for the serial frame port core-side outputs
`default_nettype none
module sfp_port_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_overrun,
  input wire logic [15:0] pin_fn,
  input wire logic [7:0] pin_out_val,
  input wire logic busy_en,
  input wire logic conv_busy,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_analog
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Word flow toward the core
  a_word_holds: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data)) else $error("rx word moved");
  a_drop_full: assert property (rx_overrun |-> rx_valid)
    else $error("drop without full buffer");
  a_drop_pulse: assert property (rx_overrun |=> !rx_overrun)
    else $error("drop pulse too long");
  // Pin functions
  a_dout_drive: assert property ((pin_fn[1:0] == 2'h3 &&
    pin_out_val[0]) [*3] |-> pin_oe[0] && pin_o[0]) else $error("dout");
  a_din_float: assert property (pin_fn[3:2] == 2'h2 [*3]
    |-> !pin_oe[1]) else $error("din driven");
  a_ain_analog: assert property (pin_fn[5:4] == 2'h1 [*3]
    |-> pin_analog[2] && !pin_oe[2]) else $error("ain");
  a_aout_analog: assert property (pin_fn[7:6] == 2'h0 [*3]
    |-> pin_analog[3]) else $error("aout");
  a_busy_shown: assert property ((busy_en && conv_busy) [*3]
    |-> pin_o[7] && pin_oe[7]) else $error("busy not shown");
endmodule
bind sfp_port sfp_port_chk chk (.ref_clk, .rst, .rx_data, .rx_valid,
  .rx_ready, .rx_overrun, .pin_fn, .pin_out_val, .busy_en, .conv_busy,
  .pin_oe, .pin_o, .pin_analog);
`default_nettype wire

// ===== sim/sfp_host.sv
// Behavioural serial host driving frame sync, clock and data
`default_nettype none
module sfp_host (
  output logic serial_clk,
  output logic sync_n,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] seen;
  // Idle lines at time zero
  initial begin
    serial_clk = 1'b1;
    sync_n = 1'b1;
    serial_in = 1'b0;
  end
  // One frame of n bits; clock stands at idle outside frames
  task automatic frame(input logic [15:0] w, input int n, input logic idle);
    serial_clk = idle;
    #21.3 sync_n = 1'b0;
    #15;
    for (int i = 0; i < n; i++) begin
      serial_in = i < 16 ? w[15 - i] : ~serial_in;
      serial_clk = 1'b1;
      #15 if (i < 16) seen = {seen[14:0], serial_out};
      serial_clk = 1'b0;
      #15;
    end
    serial_clk = idle;
    #15 sync_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule
`default_nettype wire

// ===== sim/sfp_port_bench.sv
// Bench for the serial frame port
`default_nettype none
module sfp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rx_ready = 1'b0;
  logic tx_load = 1'b0;
  logic busy_en = 1'b0;
  logic conv_busy = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic [15:0] pin_fn = 16'h5555;
  logic [7:0] pin_out_val = 8'hFF;
  logic [7:0] pin_i = 8'hFF;
  logic serial_clk, sync_n, serial_in, serial_out, rx_valid, rx_overrun;
  logic [15:0] rx_data;
  logic [7:0] pin_oe, pin_o, pin_in_val, pin_analog;
  int err_total = 0;
  int compares = 0;
  bit dropped = 1'b0;
  sfp_port dut (.ref_clk, .rst, .serial_clk, .sync_n, .serial_in,
    .serial_out, .rx_data, .rx_valid, .rx_ready, .rx_overrun, .tx_data,
    .tx_load, .pin_fn, .pin_out_val, .busy_en, .conv_busy, .pin_oe, .pin_o,
    .pin_in_val, .pin_i, .pin_analog);
  sfp_host host (.serial_clk, .sync_n, .serial_in, .serial_out);
  // Core clock and drop monitor
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rx_overrun === 1'b1) dropped <= 1'b1;
  task automatic cmp(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wait for a word, compare it and take it
  task automatic take(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (rx_valid !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    cmp("rx_data", exp, rx_data);
    rx_ready <= 1'b1;
    @(posedge ref_clk);
    rx_ready <= 1'b0;
  endtask
  task automatic t_frame(input logic [15:0] tw, rw, input logic idle);
    @(posedge ref_clk);
    tx_data <= tw;
    tx_load <= 1'b1;
    @(posedge ref_clk);
    tx_load <= 1'b0;
    repeat (8) @(posedge ref_clk);
    host.frame(rw, 16, idle);
    cmp("serial_out", tw, host.seen);
    take(rw);
  endtask
  task automatic t_odd();
    host.frame(16'hFFFF, 10, 1'b1);
    host.frame(16'h0F0F, 18, 1'b0);
    take(16'h0F0F);
    repeat (20) @(posedge ref_clk);
    cmp("rx_valid", 16'h0000, {15'h0000, rx_valid});
    cmp("rx_overrun", 16'h0000, {15'h0000, dropped});
  endtask
  task automatic t_stall();
    for (int k = 1; k < 5; k++) host.frame({4{k[3:0]}}, 16, 1'b1);
    // Let the last word cross before the drop flag is judged
    repeat (8) @(posedge ref_clk);
    cmp("rx_overrun", 16'h0001, {15'h0000, dropped});
    // The waiting third word gives way to the fourth
    for (int k = 1; k < 3; k++) take({4{k[3:0]}});
    take(16'h4444);
    repeat (20) @(posedge ref_clk);
    cmp("rx_valid", 16'h0000, {15'h0000, rx_valid});
  endtask
  task automatic t_pins();
    busy_en <= 1'b1;
    conv_busy <= 1'b1;
    repeat (10) @(posedge ref_clk);
    cmp("busy_pin", 16'h0003, {14'h0000, pin_oe[7], pin_o[7]});
    busy_en <= 1'b0;
    conv_busy <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      pin_fn <= {8{c[1:0]}};
      pin_out_val <= {4{c[1:0]}};
      pin_i <= ~{4{c[1:0]}};
      repeat (10) @(posedge ref_clk);
      cmp("pin_oe", {8'h00, {8{c == 3}}}, {8'h00, pin_oe});
      cmp("pin_o", {8'h00, {4{c[1:0]}}}, {8'h00, pin_o});
      cmp("pin_analog", {8'h00, {8{c < 2}}}, {8'h00, pin_analog});
      cmp("pin_in_val", {8'h00, 8'h55 & {8{c == 2}}},
        {8'h00, pin_in_val});
    end
  endtask
  task automatic conclude();
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #50000;
    err_total++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_pins();
    t_frame(16'hA5C3, 16'h1234, 1'b1);
    t_frame(16'h8001, 16'hFFFE, 1'b0);
    t_odd();
    t_stall();
    conclude();
  end
endmodule
`default_nettype wire
